// >>> acrd_clock_detect.sv
// Audio clock detection, ratio check and converter clock selection.
// How it works
// - Override bit forces path power-up high.
// - Presence detector, dividers keep running under override.
// - Only ratios 256, 400, 500 are accepted.
// - Multiplier 1,2,4,8 scales counted master clock.
// - Ratio 256 uses programmed oversampling ratio.
// - Ratios 400, 500 force oversampling 100.
// - Ratio 500 forces divide-by-five automatically.
// - Valid after one hit, invalid after two misses.
// - Bit clock valid needs 32 cycles per frame.
// - Without override, power-up only while every condition holds.
`timescale 1ns/10ps
module acrd_clock_detect (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        mclk_in,
  input  wire logic        bclk_in,
  input  wire logic        fs_in,
  input  wire logic        reg_wr_en_in,
  input  wire logic        reg_rd_en_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        sample_valid_in,
  input  wire logic        sample_zero_in,
  output logic      [15:0] reg_rdata_out,
  output logic             path_power_up_out,
  output logic             master_clock_present_out,
  output logic      [1:0]  clk_mult_out,
  output logic      [1:0]  clk_pre_div_out,
  output logic      [2:0]  adc_clk_div_out,
  output logic      [2:0]  dac_clk_div_out,
  output logic      [2:0]  adc_osr_out,
  output logic      [2:0]  dac_osr_out,
  output logic      [2:0]  sample_rate_range_out
);

  // Scaled count window test: x within n1*(r-2) .. n1*(r+2).
  function automatic logic in_win(input logic [18:0] x,
                                  input logic [15:0] r,
                                  input logic [1:0]  n1);
    logic [18:0] lo;
    logic [18:0] hi;
    lo = 19'(({3'h0, r} - {3'h0, acrd_pkg::RATIO_TOL}) * {17'h0, n1});
    hi = 19'(({3'h0, r} + {3'h0, acrd_pkg::RATIO_TOL}) * {17'h0, n1});
    return (x >= lo) && (x <= hi);
  endfunction : in_win

  // Classify a frame against the three accepted ratios.
  function automatic acrd_pkg::acrd_ratio_e classify(input logic [18:0] x,
                                                     input logic [1:0]  n1);
    acrd_pkg::acrd_ratio_e c;
    c = acrd_pkg::ACRD_R_NONE;
    if (in_win(x, acrd_pkg::RATIO_A, n1)) begin
      c = acrd_pkg::ACRD_R_256;
    end else if (in_win(x, acrd_pkg::RATIO_B, n1)) begin
      c = acrd_pkg::ACRD_R_400;
    end else if (in_win(x, acrd_pkg::RATIO_C, n1)) begin
      c = acrd_pkg::ACRD_R_500;
    end
    return c;
  endfunction : classify

  logic [15:0]           clk_div_q;
  logic [15:0]           osr_a_q;
  logic [15:0]           osr_b_q;
  logic [15:0]           det_ctrl_q;
  logic [15:0]           mclk_cnt_q;
  logic [7:0]            bclk_cnt_q;
  logic                  ratio_valid_q;
  logic                  miss_q;
  logic                  bclk_valid_q;
  logic                  nz_ok_q;
  logic [10:0]           zero_cnt_q;
  acrd_pkg::acrd_ratio_e ratio_q;
  logic                  mclk_rise;
  logic                  mclk_present;
  logic                  bclk_rise;
  logic                  fs_rise;

  // Each input pin is synchronised and watched for activity.
  acrd_pin_watch #(.HOLD_CYC(acrd_pkg::MCLK_HOLD_CYC)) u_mclk (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .pin_in      (mclk_in),
    .rise_out    (mclk_rise),
    .present_out (mclk_present)
  );
  acrd_pin_watch #(.HOLD_CYC(acrd_pkg::MCLK_HOLD_CYC)) u_bclk (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .pin_in      (bclk_in),
    .rise_out    (bclk_rise),
    .present_out ()
  );
  acrd_pin_watch #(.HOLD_CYC(acrd_pkg::MCLK_HOLD_CYC)) u_fs (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .pin_in      (fs_in),
    .rise_out    (fs_rise),
    .present_out ()
  );

  // Field decode and the scaled frame count.
  wire  [1:0]  mult_sel = clk_div_q[acrd_pkg::MULT_LSB +: 2];
  wire  [1:0]  pre_sel  = clk_div_q[acrd_pkg::PREDIV_LSB +: 2];
  wire  [1:0]  n1       = (pre_sel == 2'h3) ? 2'h3 : 2'(pre_sel + 2'h1);
  wire  [18:0] scaled   = {3'h0, mclk_cnt_q} << mult_sel;
  wire  acrd_pkg::acrd_ratio_e hit = classify(scaled, n1);
  wire         override = det_ctrl_q[acrd_pkg::OVR_BIT];
  wire         nz_gate  = det_ctrl_q[acrd_pkg::NZ_GATE_BIT];
  wire         fixed100 = (ratio_q == acrd_pkg::ACRD_R_400) ||
                          (ratio_q == acrd_pkg::ACRD_R_500);
  wire         all_ok   = mclk_present & ratio_valid_q & bclk_valid_q &
                          (~nz_gate | nz_ok_q);
  wire  [15:0] status   = {2'h0, path_power_up_out, ratio_q, bclk_valid_q,
                           ratio_valid_q, mclk_present, 8'h00};
  wire  [15:0] rd_word  =
    (reg_addr_in == acrd_pkg::ADDR_CLK_DIV)  ? clk_div_q :
    (reg_addr_in == acrd_pkg::ADDR_OSR_A)    ? osr_a_q :
    (reg_addr_in == acrd_pkg::ADDR_OSR_B)    ? osr_b_q :
    (reg_addr_in == acrd_pkg::ADDR_DET_CTRL) ? (det_ctrl_q | status) :
    16'h0000;

  // Register writes and registered read data.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      clk_div_q     <= acrd_pkg::CLK_DIV_RST;
      osr_a_q       <= acrd_pkg::OSR_RST;
      osr_b_q       <= acrd_pkg::OSR_RST;
      det_ctrl_q    <= acrd_pkg::DET_CTRL_RST;
      reg_rdata_out <= 16'h0000;
    end else begin
      if (reg_wr_en_in && reg_addr_in == acrd_pkg::ADDR_CLK_DIV) begin
        clk_div_q <= reg_wdata_in;
      end
      if (reg_wr_en_in && reg_addr_in == acrd_pkg::ADDR_OSR_A) begin
        osr_a_q <= reg_wdata_in;
      end
      if (reg_wr_en_in && reg_addr_in == acrd_pkg::ADDR_OSR_B) begin
        osr_b_q <= reg_wdata_in;
      end
      if (reg_wr_en_in && reg_addr_in == acrd_pkg::ADDR_DET_CTRL) begin
        det_ctrl_q <= reg_wdata_in & acrd_pkg::DET_CTRL_WMASK;
      end
      if (reg_rd_en_in) begin
        reg_rdata_out <= rd_word;
      end
    end
  end

  // Per-frame counting of master and bit clock edges.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mclk_cnt_q <= 16'h0000;
      bclk_cnt_q <= 8'h00;
    end else if (fs_rise) begin
      mclk_cnt_q <= {15'h0000, mclk_rise};
      bclk_cnt_q <= {7'h00, bclk_rise};
    end else begin
      if (mclk_rise && mclk_cnt_q != 16'hFFFF) begin
        mclk_cnt_q <= mclk_cnt_q + 16'h0001;
      end
      if (bclk_rise && bclk_cnt_q != 8'hFF) begin
        bclk_cnt_q <= bclk_cnt_q + 8'h01;
      end
    end
  end

  // Ratio and bit clock verdict at each frame sync edge.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ratio_valid_q <= 1'b0;
      miss_q        <= 1'b0;
      ratio_q       <= acrd_pkg::ACRD_R_NONE;
      bclk_valid_q  <= 1'b0;
    end else if (!mclk_present) begin
      ratio_valid_q <= 1'b0;
      miss_q        <= 1'b0;
      ratio_q       <= acrd_pkg::ACRD_R_NONE;
    end else if (fs_rise) begin
      bclk_valid_q <= (bclk_cnt_q >= acrd_pkg::MIN_BCLK);
      if (hit != acrd_pkg::ACRD_R_NONE) begin
        ratio_valid_q <= 1'b1; // One good frame suffices.
        miss_q        <= 1'b0;
        ratio_q       <= hit;
      end else if (miss_q) begin
        ratio_valid_q <= 1'b0; // Second bad frame in a row.
        ratio_q       <= acrd_pkg::ACRD_R_NONE;
      end else begin
        miss_q <= 1'b1;
      end
    end
  end

  // Non-zero sample tracking; a non-zero sample wins over the count.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      nz_ok_q    <= 1'b0;
      zero_cnt_q <= 11'h000;
    end else if (sample_valid_in) begin
      if (!sample_zero_in) begin
        nz_ok_q    <= 1'b1;
        zero_cnt_q <= 11'h000;
      end else if (zero_cnt_q == acrd_pkg::ZERO_LAST) begin
        nz_ok_q <= 1'b0;
      end else begin
        zero_cnt_q <= zero_cnt_q + 11'h001;
      end
    end
  end

  // Output stage: power-up gate and converter clock selection.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      path_power_up_out        <= 1'b0;
      master_clock_present_out <= 1'b0;
      clk_mult_out             <= 2'h0;
      clk_pre_div_out          <= 2'h0;
      adc_clk_div_out          <= 3'h0;
      dac_clk_div_out          <= 3'h0;
      adc_osr_out              <= 3'h0;
      dac_osr_out              <= 3'h0;
      sample_rate_range_out    <= 3'h0;
    end else begin
      path_power_up_out        <= override | all_ok;
      master_clock_present_out <= mclk_present;
      clk_mult_out             <= mult_sel;
      clk_pre_div_out          <= pre_sel;
      sample_rate_range_out    <= det_ctrl_q[acrd_pkg::SRATE_LSB +: 3];
      if (ratio_q == acrd_pkg::ACRD_R_500) begin
        adc_clk_div_out <= acrd_pkg::DIV_BY_5;
        dac_clk_div_out <= acrd_pkg::DIV_BY_5;
      end else begin
        adc_clk_div_out <= clk_div_q[acrd_pkg::ADC_DIV_LSB +: 3];
        dac_clk_div_out <= clk_div_q[acrd_pkg::DAC_DIV_LSB +: 3];
      end
      if (fixed100) begin
        adc_osr_out <= acrd_pkg::OSR_100;
        dac_osr_out <= acrd_pkg::OSR_100;
      end else begin
        adc_osr_out <= {1'b0, osr_a_q[acrd_pkg::OSR_LSB +: 2]};
        dac_osr_out <= {1'b0, osr_b_q[acrd_pkg::OSR_LSB +: 2]};
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Override held for two cycles gives power-up high in the second.
  override_pwr_a: assert property (override ##1 override |->
    path_power_up_out) else $error("override set but power-up low");
  // Presence keeps following master clock under override.
  mclk_det_a: assert property (override && mclk_rise |->
    ##1 master_clock_present_out) else $error("presence lost under override");
  // One good frame marks the ratio valid.
  win_valid_a: assert property (mclk_present && fs_rise &&
    hit != acrd_pkg::ACRD_R_NONE |=> ratio_valid_q)
    else $error("good frame not accepted");
  // A single bad frame does not drop a valid ratio.
  one_miss_a: assert property (fs_rise && ratio_valid_q && !miss_q &&
    mclk_present && hit == acrd_pkg::ACRD_R_NONE |=> ratio_valid_q)
    else $error("ratio dropped after one miss");
  // Too few bit clocks mark the bit clock invalid.
  bclk_short_a: assert property (mclk_present && fs_rise &&
    bclk_cnt_q < acrd_pkg::MIN_BCLK |=> !bclk_valid_q)
    else $error("short bit clock accepted");
  // Without override an invalid ratio drops power-up.
  pwr_drop_a: assert property (!override && !ratio_valid_q |=>
    !path_power_up_out) else $error("power-up without valid ratio");
  // Ratio 500 forces divide-by-five on both converters.
  div_five_a: assert property (ratio_q == acrd_pkg::ACRD_R_500 |=>
    adc_clk_div_out == acrd_pkg::DIV_BY_5 &&
    dac_clk_div_out == acrd_pkg::DIV_BY_5)
    else $error("divide by five missing");
  // Ratios 400 and 500 fix oversampling at 100.
  osr_fixed_a: assert property (fixed100 |=>
    adc_osr_out == acrd_pkg::OSR_100 && dac_osr_out == acrd_pkg::OSR_100)
    else $error("fixed oversampling missing");
  // Ratio 256 passes the programmed oversampling code.
  osr_prog_a: assert property (ratio_q == acrd_pkg::ACRD_R_256 |=>
    adc_osr_out == {1'b0, $past(osr_a_q[1:0])})
    else $error("programmed oversampling not used");
  // Frames classified as ratio 256 lie within n1*254 .. n1*258.
  ratio_set_a: assert property (fs_rise && mclk_present &&
    hit == acrd_pkg::ACRD_R_256 |-> scaled >= 19'(254) * n1 &&
    scaled <= 19'(258) * n1) else $error("ratio window wrong");

endmodule : acrd_clock_detect

// >>> acrd_pkg.sv
// Constants, field layout and types for the audio clock rate detector.
package acrd_pkg;

  // Register word addresses on the control register port.
  localparam logic [7:0]  ADDR_CLK_DIV   = 8'h03;
  localparam logic [7:0]  ADDR_OSR_A     = 8'h28;
  localparam logic [7:0]  ADDR_OSR_B     = 8'h29;
  localparam logic [7:0]  ADDR_DET_CTRL  = 8'h40;

  // Values after reset.
  localparam logic [15:0] CLK_DIV_RST    = 16'h0000;
  localparam logic [15:0] OSR_RST        = 16'h0000;
  localparam logic [15:0] DET_CTRL_RST   = 16'h0000;

  // Field positions in clock_divider_control.
  localparam int          MULT_LSB       = 0;  // Two bits: x1, x2, x4, x8.
  localparam int          PREDIV_LSB     = 2;  // Two bits: /1, /2, /3.
  localparam int          ADC_DIV_LSB    = 4;  // Three bits, divide code.
  localparam int          DAC_DIV_LSB    = 7;  // Three bits, divide code.
  // Field positions in oversampling_control_a and _b.
  localparam int          OSR_LSB        = 0;  // Two bits: 32..256.
  // Field positions in clock_detect_control.
  localparam int          OVR_BIT        = 0;
  localparam int          NZ_GATE_BIT    = 1;
  localparam int          SRATE_LSB      = 2;  // Three bits.
  localparam int          ST_MCLK_BIT    = 8;
  localparam int          ST_RATIO_BIT   = 9;
  localparam int          ST_BCLK_BIT    = 10;
  localparam int          ST_RCODE_LSB   = 11; // Two bits, ratio code.
  localparam int          ST_PWR_BIT     = 13;
  localparam logic [15:0] DET_CTRL_WMASK = 16'h001F;

  // Ratio targets and tolerance, in scaled master clock cycles.
  localparam logic [15:0] RATIO_A        = 16'h0100;
  localparam logic [15:0] RATIO_B        = 16'h0190;
  localparam logic [15:0] RATIO_C        = 16'h01F4;
  localparam logic [15:0] RATIO_TOL      = 16'h0002;

  // Bit clock and zero sample limits.
  localparam logic [7:0]  MIN_BCLK       = 8'h20;
  localparam logic [10:0] ZERO_LAST      = 11'h7FF; // 2048 zero samples.

  // Master clock release time and its cycle count at 25 MHz.
  localparam int          MCLK_RELEASE_NS = 50000;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          MCLK_HOLD_CYC   = MCLK_RELEASE_NS / CLK_PERIOD_NS;

  // Converter divider and oversampling codes.
  localparam logic [2:0]  DIV_BY_5       = 3'h5;
  localparam logic [2:0]  OSR_100        = 3'h4;

  // Detected internal ratio.
  typedef enum logic [1:0] {
    ACRD_R_NONE = 2'b00,
    ACRD_R_256  = 2'b01,
    ACRD_R_400  = 2'b10,
    ACRD_R_500  = 2'b11
  } acrd_ratio_e;

endpackage : acrd_pkg

// >>> acrd_pin_watch.sv
// Pin synchroniser with rising edge pulse and activity watchdog.
`timescale 1ns/10ps
module acrd_pin_watch #(
  parameter int HOLD_CYC = 1250
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      present_out
);

  logic        s1_q;
  logic        s2_q;
  logic        s3_q;
  logic [15:0] idle_q;
  logic        rise_d;

  // A rise is seen only on the second and third stages.
  assign rise_d = s2_q & ~s3_q;

  // Two stage synchroniser, edge stage and idle timer.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s1_q        <= 1'b0;
      s2_q        <= 1'b0;
      s3_q        <= 1'b0;
      idle_q      <= 16'h0000;
      rise_out    <= 1'b0;
      present_out <= 1'b0;
    end else begin
      s1_q     <= pin_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      rise_out <= rise_d;
      if (rise_d) begin
        idle_q      <= 16'h0000;
        present_out <= 1'b1;
      end else if (idle_q >= 16'(HOLD_CYC - 1)) begin
        present_out <= 1'b0; // No edge for the release time.
      end else begin
        idle_q <= idle_q + 16'h0001;
      end
    end
  end

endmodule : acrd_pin_watch

// >>> acrd_host_model.sv
// Behavioural audio host that drives master clock, bit clock and frame sync.
`timescale 1ns/10ps
module acrd_host_model (
  input  wire logic        run_in,
  input  wire logic [15:0] ratio_in,
  input  wire logic [7:0]  bclk_div_in,
  output logic             mclk_out,
  output logic             bclk_out,
  output logic             fs_out
);
  logic [15:0] idx_q;
  logic [15:0] ratio_q;
  logic [7:0]  div_q;

  // Master clock of 5 MHz that stands still while stopped.
  // Edges sit 10 ns off the 40 ns grid, so they never meet a system edge.
  initial begin
    mclk_out = 1'b0;
    bclk_out = 1'b0;
    fs_out = 1'b0;
    idx_q = 16'h0000;
    ratio_q = 16'h0100;
    div_q = 8'h04;
    #10;
    forever begin
      #100;
      if (run_in) begin
        mclk_out = ~mclk_out;
        if (mclk_out) begin
          // Frame length and bit clock split change only at a frame start.
          if (idx_q + 16'h0001 >= ratio_q) begin
            idx_q = 16'h0000;
            ratio_q = ratio_in;
            div_q = bclk_div_in;
          end else begin
            idx_q = idx_q + 16'h0001;
          end
          fs_out = (idx_q < (ratio_q >> 1));
          bclk_out = ((idx_q % div_q) < (div_q >> 1));
        end
      end
    end
  end
endmodule : acrd_host_model

// >>> tb_audio_clock_rate_detect.sv
// Self-checking testbench for the audio clock rate detector.
`timescale 1ns/10ps
module tb_audio_clock_rate_detect;
  logic        clk_in, rst_b_in, mclk, bclk, fs, wr_en, rd_en;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, rd_v;
  logic        s_valid, s_zero, run, pwr, mpres;
  logic [15:0] ratio;
  logic [7:0]  bdiv;
  logic [1:0]  mult, prediv;
  logic [2:0]  adiv, ddiv, aosr, dosr, srange;
  int          miscompares = 0;
  int          n_checks = 0;

  acrd_host_model partner (.run_in(run), .ratio_in(ratio),
    .bclk_div_in(bdiv), .mclk_out(mclk), .bclk_out(bclk), .fs_out(fs));

  acrd_clock_detect DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .mclk_in(mclk), .bclk_in(bclk), .fs_in(fs), .reg_wr_en_in(wr_en),
    .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .sample_valid_in(s_valid), .sample_zero_in(s_zero),
    .reg_rdata_out(rdata), .path_power_up_out(pwr),
    .master_clock_present_out(mpres), .clk_mult_out(mult),
    .clk_pre_div_out(prediv), .adc_clk_div_out(adiv),
    .dac_clk_div_out(ddiv), .adc_osr_out(aosr), .dac_osr_out(dosr),
    .sample_rate_range_out(srange));

  // System clock of 25 MHz.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One register write, taken at the second edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : wr

  // One register read; the data is taken once it has landed.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd_en <= 1'b0;
    @(posedge clk_in);
    #1 rd_v = rdata;
  endtask : rd

  // Sets the host's frame shape; it takes effect at the next frame.
  task automatic host(input logic [15:0] r, input logic [7:0] d);
    @(posedge clk_in);
    run <= 1'b1;
    ratio <= r;
    bdiv <= d;
  endtask : host

  // Waits for frame starts, then lets the verdict settle.
  task automatic frames(input int n);
    repeat (n) @(posedge fs);
    repeat (10) @(posedge clk_in);
    #1;
  endtask : frames

  // Registers after reset, write mask and unmapped places.
  task automatic t_regs;
    rd(8'h03); chk("div reg", rd_v, 16'h0000);
    rd(8'h29); chk("osr reg", rd_v, 16'h0000);
    rd(8'h40); chk("det reg", rd_v, 16'h0000);
    wr(8'h40, 16'hFFFF);
    wr(8'h04, 16'hFFFF);
    rd(8'h40); chk("det mask", rd_v, 16'h201F);
    rd(8'h04); chk("unmapped", rd_v, 16'h0000);
    rd(8'h03); chk("div kept", rd_v, 16'h0000);
    chk("mclk absent", 16'(mpres), 16'h0000);
  endtask : t_regs

  // Ratio 256 with programmed oversampling and dividers.
  task automatic t_256;
    wr(8'h40, 16'h0008);
    wr(8'h03, 16'h01A0);
    wr(8'h28, 16'h0001);
    wr(8'h29, 16'h0003);
    host(16'h0100, 8'h04);
    frames(3);
    chk("pwr 256", 16'(pwr), 16'h0001);
    chk("adc osr", 16'(aosr), 16'h0001);
    chk("dac osr", 16'(dosr), 16'h0003);
    chk("range", 16'(srange), 16'h0002);
    rd(8'h40); chk("status", rd_v, 16'h2F08);
  endtask : t_256

  // Ratios 400 and 500 force oversampling; 500 forces divide by five.
  task automatic t_400_500;
    wr(8'h03, 16'h0240);
    host(16'h0190, 8'h08);
    frames(3);
    chk("osr 400", 16'(aosr), 16'(acrd_pkg::OSR_100));
    chk("div 400", 16'(adiv), 16'h0004);
    chk("ddiv 400", 16'(ddiv), 16'h0004);
    host(16'h01F4, 8'h0A);
    frames(3);
    chk("osr 500", 16'(dosr), 16'(acrd_pkg::OSR_100));
    chk("adiv 500", 16'(adiv), 16'(acrd_pkg::DIV_BY_5));
    chk("ddiv 500", 16'(ddiv), 16'(acrd_pkg::DIV_BY_5));
    chk("pwr 500", 16'(pwr), 16'h0001);
  endtask : t_400_500

  // Multiplier scales short frames up to a legal ratio; pre-divide by two with x2 keeps ratio 256.
  task automatic t_mult;
    wr(8'h03, 16'h0001);
    host(16'h0080, 8'h02);
    frames(3);
    chk("pwr x2", 16'(pwr), 16'h0001);
    chk("osr x2", 16'(aosr), 16'h0001);
    wr(8'h03, 16'h0002);
    host(16'h0064, 8'h03);
    frames(3);
    chk("osr x4", 16'(aosr), 16'(acrd_pkg::OSR_100));
    wr(8'h03, 16'h0005);
    host(16'h0100, 8'h04);
    frames(3);
    chk("pwr pre2", 16'(pwr), 16'h0001);
    chk("prediv", 16'(prediv), 16'h0001);
    chk("mult x2", 16'(mult), 16'h0001);
    chk("osr pre2", 16'(aosr), 16'h0001);
  endtask : t_mult

  // One bad frame keeps the path up, the second drops it.
  task automatic t_miss;
    host(16'h012C, 8'h04);
    @(posedge fs);
    frames(1);
    chk("one miss", 16'(pwr), 16'h0001);
    frames(1);
    chk("two miss", 16'(pwr), 16'h0000);
    wr(8'h03, 16'h0000);
    host(16'h0100, 8'h04);
    @(posedge fs);
    frames(1);
    chk("one hit", 16'(pwr), 16'h0001);
  endtask : t_miss

  // Short bit clock blocks the path; override forces it on again.
  task automatic t_bclk_ovr;
    host(16'h0100, 8'h10);
    frames(3);
    chk("bclk short", 16'(pwr), 16'h0000);
    wr(8'h40, 16'h0001);
    repeat (3) @(posedge clk_in);
    #1 chk("override", 16'(pwr), 16'h0001);
    wr(8'h03, 16'h0003);
    @(posedge clk_in);
    #1 chk("mult live", 16'(mult), 16'h0003);
    chk("mclk live", 16'(mpres), 16'h0001);
  endtask : t_bclk_ovr

  // Nonzero gate waits for a nonzero sample, 2048 zeros close it; clock loss drops presence.
  task automatic t_nz_loss;
    wr(8'h03, 16'h0000);
    wr(8'h40, 16'h0002);
    host(16'h0100, 8'h04);
    frames(3);
    chk("nz wait", 16'(pwr), 16'h0000);
    @(posedge clk_in);
    s_valid <= 1'b1;
    @(posedge clk_in);
    s_valid <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1 chk("nz go", 16'(pwr), 16'h0001);
    @(posedge clk_in);
    {s_valid, s_zero} <= 2'b11;
    repeat (2047) @(posedge clk_in);
    #1 chk("zeros 2047", 16'(pwr), 16'h0001);
    @(posedge clk_in);
    s_zero <= 1'b0;
    @(posedge clk_in);
    #1 chk("zeros 2048", 16'(pwr), 16'h0000);
    @(posedge clk_in);
    s_valid <= 1'b0;
    run <= 1'b0;
    repeat (1300) @(posedge clk_in);
    #1 chk("mclk lost", 16'(mpres), 16'h0000);
    chk("pwr lost", 16'(pwr), 16'h0000);
  endtask : t_nz_loss

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    rst_b_in = 1'b0;
    {wr_en, rd_en, s_valid, s_zero, run} = 5'b00000;
    addr = 8'h00;
    wdata = 16'h0000;
    ratio = 16'h0100;
    bdiv = 8'h04;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_256();
    t_400_500();
    t_mult();
    t_miss();
    t_bclk_ovr();
    t_nz_loss();
    report_and_stop();
  end
endmodule : tb_audio_clock_rate_detect
